// ---- rtl/jaie_pkg.sv ----
// Operation
// - top bits 101 decode as absolute jump
// - jump loads literal into counter bits 8:0
// - jump copies status bits 6:5 to 10:9
// - jump takes two cycles, flags unchanged
// - plain increment adds one modulo 256, one cycle
// - destination bit 0 accumulator, 1 register
// - increment-skip skips on zero, flags untouched
// - skip discards fetched word, runs no-operation
package jaie_pkg;
   localparam int INSN_W = 12;
   localparam int DATA_W = 8;
   localparam int PC_W = 11;
   localparam int ADDR_W = 5;
   localparam int LIT_W = 9;
   localparam logic [2:0] OP_JUMP = 3'h5;
   localparam logic [5:0] OP_INC = 6'h0A;
   localparam logic [5:0] OP_INCSZ = 6'h0F;
   localparam int JUMP_HI = 11;
   localparam int JUMP_LO = 9;
   localparam int OP6_LO = 6;
   localparam int DEST_BIT = 5;
   localparam int STAT_PAGE_HI = 6;
   localparam int STAT_PAGE_LO = 5;
   localparam int STAT_ZERO = 2;
   localparam logic [INSN_W-1:0] NOP_WORD = 12'h000;
   localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [PC_W-1:0] PC_RESET = 11'h000;
   typedef enum logic [0:0] {JAIE_RUN, JAIE_FLUSH} jaie_state_e;
endpackage

// ---- rtl/jaie_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module jaie_decode
(
   input wire logic [jaie_pkg::INSN_W-1:0] insn,
   output logic is_jump,
   output logic is_inc,
   output logic is_incsz,
   output logic dest_reg,
   output logic [jaie_pkg::ADDR_W-1:0] addr,
   output logic [jaie_pkg::LIT_W-1:0] literal
);
   import jaie_pkg::*;

   assign is_jump = (insn[JUMP_HI:JUMP_LO] == OP_JUMP);
   assign is_inc = (insn[JUMP_HI:OP6_LO] == OP_INC);
   assign is_incsz = (insn[JUMP_HI:OP6_LO] == OP_INCSZ);
   assign dest_reg = insn[DEST_BIT];
   assign addr = insn[ADDR_W-1:0];
   assign literal = insn[LIT_W-1:0];
endmodule
`default_nettype wire

// ---- rtl/jaie_exec.sv ----
`timescale 1ns/1ps
`default_nettype none
module jaie_exec
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [jaie_pkg::INSN_W-1:0] insn_word,
   input wire logic [jaie_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [jaie_pkg::DATA_W-1:0] status_in,
   output logic [jaie_pkg::ADDR_W-1:0] reg_raddr,
   output logic [jaie_pkg::PC_W-1:0] program_counter,
   output logic [jaie_pkg::ADDR_W-1:0] reg_waddr,
   output logic [jaie_pkg::DATA_W-1:0] reg_wdata,
   output logic reg_we,
   output logic [jaie_pkg::DATA_W-1:0] acc_wdata,
   output logic acc_we,
   output logic zero_wdata,
   output logic zero_we,
   output logic no_operation,
   output logic busy
);
   import jaie_pkg::*;

   jaie_state_e state_reg;
   jaie_state_e state_next;
   logic [PC_W-1:0] pc_reg;
   logic [PC_W-1:0] pc_next;
   logic [ADDR_W-1:0] waddr_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic rwe_reg;
   logic awe_reg;
   logic zwe_reg;
   logic zval_reg;
   logic nop_reg;
   logic busy_reg;

   logic is_jump;
   logic is_inc;
   logic is_incsz;
   logic dest_reg;
   logic [ADDR_W-1:0] addr;
   logic [LIT_W-1:0] literal;

   // discarded word is never decoded, so it cannot fire twice
   wire executing = (state_reg == JAIE_RUN);
   wire [INSN_W-1:0] insn_eff = executing ? insn_word : NOP_WORD;

   jaie_decode u_dec
   (
      .insn(insn_eff),
      .is_jump(is_jump),
      .is_inc(is_inc),
      .is_incsz(is_incsz),
      .dest_reg(dest_reg),
      .addr(addr),
      .literal(literal)
   );

   wire do_inc = is_inc || is_incsz;
   // register file read is combinational on the same cycle
   wire [DATA_W-1:0] sum = reg_rdata + DATA_ONE;
   wire sum_zero = (sum == DATA_ZERO);
   wire skip = is_incsz && sum_zero;
   wire [PC_W-1:0] jump_pc = {status_in[STAT_PAGE_HI:STAT_PAGE_LO], literal};
   wire [PC_W-1:0] pc_inc = pc_reg + PC_W'(1);
   wire rwe_next = do_inc && dest_reg;
   wire awe_next = do_inc && !dest_reg;
   // only the plain increment touches the zero flag
   wire zwe_next = is_inc;
   wire nop_next = !executing;
   wire busy_next = (state_next == JAIE_FLUSH);

   always_comb
   begin
      pc_next = pc_inc;
      state_next = JAIE_RUN;
      if (is_jump)
      begin
         pc_next = jump_pc;
         state_next = JAIE_FLUSH;
      end
      else if (skip)
      begin
         state_next = JAIE_FLUSH;
      end
   end

   // control state: flush slot, its no-operation marker and busy
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         state_reg <= JAIE_RUN;
         nop_reg <= 1'b0;
         busy_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         state_reg <= state_next;
         nop_reg <= nop_next;
         busy_reg <= busy_next;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         pc_reg <= PC_RESET;
      end
      else if (clk_en)
      begin
         pc_reg <= pc_next;
      end
   end

   // one result register feeds both accumulator and register file
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         waddr_reg <= '0;
         wdata_reg <= DATA_ZERO;
         rwe_reg <= 1'b0;
         awe_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         waddr_reg <= addr;
         wdata_reg <= sum;
         rwe_reg <= rwe_next;
         awe_reg <= awe_next;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         zwe_reg <= 1'b0;
         zval_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         zwe_reg <= zwe_next;
         zval_reg <= sum_zero;
      end
   end

   assign reg_raddr = addr;
   assign program_counter = pc_reg;
   assign reg_waddr = waddr_reg;
   assign reg_wdata = wdata_reg;
   assign reg_we = rwe_reg;
   assign acc_wdata = wdata_reg;
   assign acc_we = awe_reg;
   assign zero_wdata = zval_reg;
   assign zero_we = zwe_reg;
   assign no_operation = nop_reg;
   assign busy = busy_reg;

   a_jump_target: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && is_jump |=> program_counter == $past(jump_pc))
      else $error("jump target wrong");
   a_jump_page: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && is_jump |=> program_counter[PC_W-1:LIT_W]
         == $past(status_in[STAT_PAGE_HI:STAT_PAGE_LO]))
      else $error("jump page wrong");
   sequence s_jump_taken;
      clk_en && is_jump;
   endsequence
   sequence s_flush_slot;
      !executing && busy;
   endsequence
   sequence s_flush_taken;
      clk_en && !executing;
   endsequence
   a_jump_two_cycle: assert property (@(posedge mclk) disable iff (sys_rst)
      s_jump_taken |=> s_flush_slot)
      else $error("jump not two cycles");
   a_flush_nop: assert property (@(posedge mclk) disable iff (sys_rst)
      s_flush_taken |=> no_operation && executing)
      else $error("discarded word not replaced");
   a_flush_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
      s_flush_taken |=> !reg_we && !acc_we && !zero_we
         && program_counter == $past(program_counter) + PC_W'(1))
      else $error("discarded word had effect");
   a_jump_decode: assert property (@(posedge mclk) disable iff (sys_rst)
      executing && insn_word[JUMP_HI:JUMP_LO] == OP_JUMP |-> is_jump)
      else $error("jump not decoded");
   a_inc_wrap: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && do_inc && reg_rdata == 8'hFF |=> reg_wdata == DATA_ZERO)
      else $error("increment wrap wrong");
   a_dest_select: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && do_inc |=> (reg_we == $past(dest_reg)) && (acc_we != reg_we))
      else $error("destination wrong");
   a_incsz_flags: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && (is_incsz || is_jump) |=> !zero_we)
      else $error("flag touched");
   a_skip_nop: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && skip |=> !executing && busy)
      else $error("skip missed");
   a_zero_flag: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && is_inc |=> zero_we && zero_wdata == (reg_wdata == DATA_ZERO))
      else $error("zero flag wrong");
   a_inc_single: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && is_inc |=> executing)
      else $error("increment not single cycle");
   a_pc_step: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && !is_jump |=> program_counter == $past(program_counter) + PC_W'(1))
      else $error("counter did not advance");
   a_freeze_hold: assert property (@(posedge mclk) disable iff (sys_rst)
      !clk_en |=> $stable(program_counter) && $stable(busy) && $stable(reg_we))
      else $error("state moved while frozen");
   a_reset_quiet: assert property (@(posedge mclk)
      sys_rst |=> !reg_we && !acc_we && !zero_we && !busy && !no_operation
         && program_counter == PC_RESET)
      else $error("reset left outputs active");
   a_jump_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && is_jump |=> !reg_we && !acc_we)
      else $error("jump wrote a result");
   a_inc_sum: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && do_inc |=> reg_wdata == $past(reg_rdata) + DATA_ONE)
      else $error("increment result wrong");
   a_waddr_track: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && do_inc |=> reg_waddr == $past(insn_word[ADDR_W-1:0]))
      else $error("write address wrong");
endmodule
`default_nettype wire

// ---- test/jaie_exec_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module jump_and_increment_exec_tb_top;
   import jaie_pkg::*;
   typedef struct {logic [11:0] w; logic [7:0] d; int dst; logic [7:0] r; logic zw; logic z;
      logic b;} jaie_row_s;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic [11:0] insn_word = 12'h000;
   logic [7:0] reg_rdata = 8'h00;
   logic [7:0] status_in = 8'h00;
   logic [4:0] reg_raddr, reg_waddr;
   logic [10:0] program_counter;
   logic [7:0] reg_wdata, acc_wdata;
   logic reg_we, acc_we, zero_wdata, zero_we, no_operation, busy;
   int num_errors = 0;
   int compares = 0;
   // dst 0 accumulator, 1 register; b marks a taken skip
   jaie_row_s rows [5] = '{'{12'h2A3, 8'hFF, 1, 8'h00, 1'b1, 1'b1, 1'b0},
      '{12'h29F, 8'h41, 0, 8'h42, 1'b1, 1'b0, 1'b0}, '{12'h3E5, 8'h10, 1, 8'h11, 1'b0, 1'b0, 1'b0},
      '{12'h3C7, 8'hFF, 0, 8'h00, 1'b0, 1'b0, 1'b1}, '{12'h3FF, 8'h7F, 1, 8'h80, 1'b0, 1'b0, 1'b0}};
   jaie_exec DUT (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .insn_word(insn_word),
      .reg_rdata(reg_rdata), .status_in(status_in), .reg_raddr(reg_raddr),
      .program_counter(program_counter), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .acc_wdata(acc_wdata), .acc_we(acc_we), .zero_wdata(zero_wdata),
      .zero_we(zero_we), .no_operation(no_operation), .busy(busy));
   always #5 mclk = ~mclk;
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // drive one word, let one edge take it, look at the answer a half cycle later
   // fl marks a word that lands in a flush slot: it reads register 0
   task automatic run(input logic [11:0] w, input logic [7:0] d, input logic fl);
      insn_word = w;
      reg_rdata = d;
      #1 chk("reg_raddr", reg_raddr, fl ? 5'h00 : w[4:0]);
      @(negedge mclk);
   endtask
   task automatic final_report();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      repeat (3000) @(posedge mclk);
      num_errors++;
      final_report();
   end
   initial
   begin
      repeat (20) @(negedge mclk);
      sys_rst = 1'b0;
      chk("program_counter", program_counter, PC_RESET);
      chk("busy", busy, 1'b0);
      $display("reset test done");
      foreach (rows[i])
      begin
         run(rows[i].w, rows[i].d, 1'b0);
         chk("acc_we", acc_we, rows[i].dst == 0);
         chk("reg_we", reg_we, rows[i].dst == 1);
         chk("wdata", rows[i].dst == 0 ? acc_wdata : reg_wdata, rows[i].r);
         if (rows[i].dst == 1)
            chk("reg_waddr", reg_waddr, rows[i].w[4:0]);
         chk("zero_we", zero_we, rows[i].zw);
         if (rows[i].zw)
            chk("zero_wdata", zero_wdata, rows[i].z);
         chk("busy", busy, rows[i].b);
         // filler would write register 3 unless it is the discarded word
         run(12'h2A3, 8'h00, rows[i].b);
         chk("no_operation", no_operation, rows[i].b);
         chk("reg_we", reg_we, !rows[i].b);
      end
      $display("increment table done");
      status_in = 8'h60;
      run(12'hA05, 8'h00, 1'b0);
      chk("program_counter", program_counter, 11'h605);
      chk("busy", busy, 1'b1);
      chk("flag writes", {zero_we, acc_we, reg_we}, 3'h0);
      run(12'h2A3, 8'h00, 1'b1);
      chk("no_operation", no_operation, 1'b1);
      chk("reg_we", reg_we, 1'b0);
      status_in = 8'h9F;
      run(12'hBFF, 8'h00, 1'b0);
      chk("program_counter", program_counter, 11'h1FF);
      run(12'h000, 8'h00, 1'b1);
      $display("jump test done");
      // a jump word while frozen must neither move the counter nor start a flush
      clk_en = 1'b0;
      run(12'hA05, 8'h00, 1'b0);
      chk("writes frozen", {acc_we, reg_we}, 2'h0);
      chk("program_counter", program_counter, 11'h200);
      chk("busy", busy, 1'b0);
      clk_en = 1'b1;
      sys_rst = 1'b1;
      run(12'h2A3, 8'h00, 1'b0);
      sys_rst = 1'b0;
      chk("program_counter", program_counter, PC_RESET);
      chk("reg_we", reg_we, 1'b0);
      run(12'h2A3, 8'hFF, 1'b0);
      chk("reg_we", reg_we, 1'b1);
      chk("zero_wdata", zero_wdata, 1'b1);
      $display("freeze and reset test done");
      final_report();
   end
endmodule
`default_nettype wire
